// File: design/fta_line_edge.sv
`timescale 1ns/1ps
module fta_line_edge #(
   parameter int N = 3
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [N-1:0] lines,
   output logic [N-1:0] rise
);
   logic [N-1:0] meta_q;
   logic [N-1:0] sync_q;
   logic [N-1:0] prev_q;

   // Two-stage synchroniser; only the second stage feeds the edge detector
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_q <= '0;
         sync_q <= '0;
         prev_q <= '0;
      end else begin
         meta_q <= lines;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // One pulse per rising edge
   assign rise = sync_q & ~prev_q;
endmodule

// File: design/fta_pkg.sv
package fta_pkg;

   // Data path and register widths
   localparam int DATA_W = 32;
   localparam int ADDR_W = 6;
   localparam int FRAME_CNT_W = 32;
   localparam int STAMP_W = 64;
   localparam int LINE_N = 3;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] ADDR_MODE = 6'h00;
   localparam logic [ADDR_W-1:0] ADDR_CHUNK_SEL = 6'h04;
   localparam logic [ADDR_W-1:0] ADDR_CHUNK_EN = 6'h08;
   localparam logic [ADDR_W-1:0] ADDR_CNT_SEL = 6'h0c;
   localparam logic [ADDR_W-1:0] ADDR_CNT_EVT = 6'h10;
   localparam logic [ADDR_W-1:0] ADDR_CLR_SRC = 6'h14;
   localparam logic [ADDR_W-1:0] ADDR_CLR_CMD = 6'h18;
   localparam logic [ADDR_W-1:0] ADDR_FRAME_CNT = 6'h1c;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 6'h20;

   // Field positions
   localparam int MODE_ON_BIT = 0;
   localparam int CHUNK_EN_BIT = 0;
   localparam int CLR_CMD_BIT = 0;
   localparam int STAT_KIND_BIT = 0;
   localparam int STAT_TRAIL_BIT = 1;

   // Counter instance chooser and counted event choice codes
   localparam logic [1:0] CNT_INST_FIRST = 2'h0;
   localparam logic [1:0] CNT_INST_SECOND = 2'h1;
   localparam logic [1:0] CNT_EVT_NONE = 2'h0;
   localparam logic [1:0] CNT_EVT_FRAME_BEGIN = 2'h1;

   // AXI4-Lite responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Time stamp tick: 8 ns per tick, clock period 5 ns, both in ps
   localparam int CLK_PERIOD_PS = 5000;
   localparam int TICK_PERIOD_PS = 8000;

   typedef enum logic [1:0] {
      CHUNK_INFO = 2'b00,
      CHUNK_COUNT = 2'b01,
      CHUNK_STAMP = 2'b10
   } fta_chunk_t;

   typedef enum logic [2:0] {
      CLR_OFF = 3'b000,
      CLR_LINE_ONE = 3'b001,
      CLR_LINE_TWO = 3'b010,
      CLR_LINE_THREE = 3'b011,
      CLR_SOFT = 3'b100
   } fta_clear_origin_t;

   typedef enum logic [1:0] {
      ST_IMAGE = 2'b00,
      ST_TRAIL = 2'b01
   } fta_state_t;

   // Trailer word order
   localparam logic [3:0] W_OFFX = 4'h0;
   localparam logic [3:0] W_WIDTH = 4'h1;
   localparam logic [3:0] W_HEIGHT = 4'h2;
   localparam logic [3:0] W_PIXFMT = 4'h3;
   localparam logic [3:0] W_DRMIN = 4'h4;
   localparam logic [3:0] W_DRMAX = 4'h5;
   localparam logic [3:0] W_COUNT = 4'h6;
   localparam logic [3:0] W_STAMP_LO = 4'h7;
   localparam logic [3:0] W_STAMP_HI = 4'h8;
   localparam logic [3:0] W_DONE = 4'hf;

   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic last;
   } fta_beat_t;

   typedef struct packed {
      logic [15:0] offset_x;
      logic [15:0] width;
      logic [15:0] height;
      logic [31:0] pix_fmt;
      logic [15:0] dr_min;
      logic [15:0] dr_max;
   } fta_frame_info_t;

endpackage

// File: design/fta_stamp_timer.sv
`timescale 1ns/1ps
module fta_stamp_timer
   import fta_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   output logic [STAMP_W-1:0] stamp
);
   localparam int ACC_W = 16;
   localparam logic [ACC_W-1:0] STEP = ACC_W'(CLK_PERIOD_PS);
   localparam logic [ACC_W-1:0] TICK = ACC_W'(TICK_PERIOD_PS);

   logic [ACC_W-1:0] acc_q;
   logic [ACC_W-1:0] acc_sum;
   logic tick_en;
   logic [STAMP_W-1:0] stamp_q;

   // Fractional divider: the tick period is not a whole number of clocks,
   // so the enable jitters by one clock but never drifts
   assign acc_sum = acc_q + STEP;
   assign tick_en = acc_sum >= TICK;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         acc_q <= '0;
         stamp_q <= '0;
      end else begin
         acc_q <= tick_en ? acc_sum - TICK : acc_sum;
         if (tick_en) begin
            stamp_q <= stamp_q + STAMP_W'(1); // see R20
         end
      end
   end

   assign stamp = stamp_q;
endmodule

// File: design/fta_trailer_top.sv
`timescale 1ns/1ps
// How it works
// R1: Trailer mode on enables frame-info chunk automatically
// R2: Chunk enables accepted only while trailer mode on
// R3: Trailer mode off clears every chunk enable
// R4: Payload kind reports chunk data while mode on
// R5: Frame-info chunk carries offset, size, format, range
// R6: Enabled chunks follow the image data
// R7: Time stamp chunk records frame acquisition time
// R8: Host selects chunk, then sets its enable
// R9: Counter chunk appended to every completed frame
// R10: Counter is 32 bits, starts zero, wraps
// R11: Counter increments once per acquired frame
// R12: Power-up reset clears the counter
// R13: Skipped counter values after stop are tolerated
// R14: Clear source: line one, two, three, software, off
// R15: Clear disabled after reset until source chosen
// R16: Host configures second counter, frame-begin event first
// R17: Software clear command clears the counter
// R18: Line clear is a synchronised single edge event
// R19: Fixed chunk order, frame info always first
// R20: Stamp is 64-bit 8 ns ticks at frame begin
module fta_trailer_top
   import fta_pkg::*;
#(
   parameter int CNT_W = FRAME_CNT_W
) (
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   // AXI4-Lite register port
   input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [DATA_W-1:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [DATA_W-1:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // Acquisition side
   input wire logic FRAME_BEGIN_EVENT,
   input wire logic [LINE_N-1:0] INPUT_LINES,
   input wire fta_pkg::fta_frame_info_t FRAME_INFO,
   input wire fta_pkg::fta_beat_t IMG_BEAT,
   input wire logic IMG_VALID,
   output logic IMG_READY,
   // Transmitter side
   output fta_pkg::fta_beat_t TX_BEAT,
   output logic TX_VALID,
   input wire logic TX_READY,
   output logic PAYLOAD_KIND
);
   import fta_pkg::*;

   if (CNT_W < 1 || CNT_W > DATA_W) begin : g_bad_cnt_w
      $error("fta_trailer_top: counter must fit one data word");
   end

   // Register file state
   logic mode_q;
   fta_chunk_t chunk_sel_q;
   logic count_en_q;
   logic stamp_en_q;
   logic [1:0] cnt_inst_q;
   logic [1:0] cnt_evt_q;
   fta_clear_origin_t clr_src_q;
   logic [CNT_W-1:0] frame_cnt_q;
   logic [CNT_W-1:0] frame_cnt_d;

   // AXI write channel state
   logic [ADDR_W-1:0] aw_addr_q;
   logic aw_have_q;
   logic [DATA_W-1:0] w_data_q;
   logic [3:0] w_strb_q;
   logic w_have_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   // AXI read channel state
   logic [DATA_W-1:0] rdata_q;
   logic [1:0] rresp_q;
   logic rvalid_q;

   // Stream state
   fta_state_t state_q;
   logic [3:0] idx_q;
   fta_beat_t out_q;
   logic out_valid_q;
   fta_frame_info_t info_snap_q;
   logic [CNT_W-1:0] cnt_snap_q;
   logic [STAMP_W-1:0] stamp_begin_q;
   logic [STAMP_W-1:0] stamp_snap_q;
   logic count_on_q;
   logic stamp_on_q;

   logic [LINE_N-1:0] line_rise;
   logic [STAMP_W-1:0] stamp_now;

   // Address decode; the low byte lane carries every writable field
   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      return a == ADDR_MODE || a == ADDR_CHUNK_SEL || a == ADDR_CHUNK_EN ||
         a == ADDR_CNT_SEL || a == ADDR_CNT_EVT || a == ADDR_CLR_SRC ||
         a == ADDR_CLR_CMD || a == ADDR_FRAME_CNT || a == ADDR_STATUS;
   endfunction

   // Next trailer word; disabled chunks are skipped so the order stays fixed
   function automatic logic [3:0] next_word(input logic [3:0] i, input logic cnt_on, input logic st_on);
      logic [3:0] n;
      n = W_DONE;
      unique case (i)
         W_OFFX: n = W_WIDTH;
         W_WIDTH: n = W_HEIGHT;
         W_HEIGHT: n = W_PIXFMT;
         W_PIXFMT: n = W_DRMIN;
         W_DRMIN: n = W_DRMAX;
         W_DRMAX: n = cnt_on ? W_COUNT : (st_on ? W_STAMP_LO : W_DONE);
         W_COUNT: n = st_on ? W_STAMP_LO : W_DONE;
         W_STAMP_LO: n = W_STAMP_HI;
         default: n = W_DONE;
      endcase
      return n;
   endfunction

   fta_line_edge #(
      .N(LINE_N)
   ) u_line_edge (
      .clk(SYS_CLK),
      .reset_n(RESET_N),
      .lines(INPUT_LINES),
      .rise(line_rise)
   );

   fta_stamp_timer u_stamp_timer (
      .clk(SYS_CLK),
      .reset_n(RESET_N),
      .stamp(stamp_now)
   );

   // AXI handshakes; a pending response blocks new writes so only one is open
   logic wr_fire;
   logic ar_fire;
   logic wr_lane0;
   assign S_AXI_AWREADY = !aw_have_q && !bvalid_q;
   assign S_AXI_WREADY = !w_have_q && !bvalid_q;
   assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
   assign S_AXI_ARREADY = !rvalid_q;
   assign ar_fire = S_AXI_ARVALID && !rvalid_q;
   assign wr_lane0 = wr_fire && w_strb_q[0];

   // Register write strobes
   logic wr_mode;
   logic wr_chunk_sel;
   logic wr_chunk_en;
   logic wr_cnt_sel;
   logic wr_cnt_evt;
   logic wr_clr_src;
   logic wr_clr_cmd;
   assign wr_mode = wr_lane0 && aw_addr_q == ADDR_MODE;
   assign wr_chunk_sel = wr_lane0 && aw_addr_q == ADDR_CHUNK_SEL;
   assign wr_chunk_en = wr_lane0 && aw_addr_q == ADDR_CHUNK_EN && mode_q; // see R2
   assign wr_cnt_sel = wr_lane0 && aw_addr_q == ADDR_CNT_SEL;
   assign wr_cnt_evt = wr_lane0 && aw_addr_q == ADDR_CNT_EVT;
   assign wr_clr_src = wr_lane0 && aw_addr_q == ADDR_CLR_SRC;
   assign wr_clr_cmd = wr_lane0 && aw_addr_q == ADDR_CLR_CMD && w_data_q[CLR_CMD_BIT];

   // Write address and data are taken in either order and held until used
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         aw_have_q <= 1'b0;
         aw_addr_q <= '0;
         w_have_q <= 1'b0;
         w_data_q <= '0;
         w_strb_q <= '0;
      end else begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= S_AXI_AWADDR;
         end else if (wr_fire) begin
            aw_have_q <= 1'b0;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_have_q <= 1'b1;
            w_data_q <= S_AXI_WDATA;
            w_strb_q <= S_AXI_WSTRB;
         end else if (wr_fire) begin
            w_have_q <= 1'b0;
         end
      end
   end

   // Write response one cycle after both halves are present
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q <= is_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
         bvalid_q <= 1'b0;
      end
   end

   // Read mux; the frame-info enable reads as the trailer mode itself
   logic [DATA_W-1:0] rd_mux;
   logic sel_en_bit;
   assign sel_en_bit = chunk_sel_q == CHUNK_INFO ? mode_q : // see R1
      chunk_sel_q == CHUNK_COUNT ? count_en_q :
      chunk_sel_q == CHUNK_STAMP ? stamp_en_q : 1'b0;
   assign rd_mux =
      S_AXI_ARADDR == ADDR_MODE ? DATA_W'(mode_q) :
      S_AXI_ARADDR == ADDR_CHUNK_SEL ? DATA_W'(chunk_sel_q) :
      S_AXI_ARADDR == ADDR_CHUNK_EN ? DATA_W'(sel_en_bit) :
      S_AXI_ARADDR == ADDR_CNT_SEL ? DATA_W'(cnt_inst_q) :
      S_AXI_ARADDR == ADDR_CNT_EVT ? DATA_W'(cnt_evt_q) :
      S_AXI_ARADDR == ADDR_CLR_SRC ? DATA_W'(clr_src_q) :
      S_AXI_ARADDR == ADDR_FRAME_CNT ? DATA_W'(frame_cnt_q) :
      S_AXI_ARADDR == ADDR_STATUS ? DATA_W'({state_q == ST_TRAIL, PAYLOAD_KIND}) : '0;

   // Read data registered one cycle after the address is taken
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= RESP_OKAY;
      end else if (ar_fire) begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_mux;
         rresp_q <= is_mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_RREADY) begin
         rvalid_q <= 1'b0;
      end
   end

   assign S_AXI_BVALID = bvalid_q;
   assign S_AXI_BRESP = bresp_q;
   assign S_AXI_RVALID = rvalid_q;
   assign S_AXI_RDATA = rdata_q;
   assign S_AXI_RRESP = rresp_q;

   // Chunk enables: switching the mode off drops them all in the same write
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         mode_q <= 1'b0;
         chunk_sel_q <= CHUNK_INFO;
         count_en_q <= 1'b0;
         stamp_en_q <= 1'b0;
      end else begin
         if (wr_mode) begin
            mode_q <= w_data_q[MODE_ON_BIT];
         end
         if (wr_chunk_sel) begin
            chunk_sel_q <= fta_chunk_t'(w_data_q[1:0]);
         end
         if (wr_mode && !w_data_q[MODE_ON_BIT]) begin
            count_en_q <= 1'b0; // see R3
            stamp_en_q <= 1'b0; // see R3
         end else if (wr_chunk_en) begin
            // The enable lands on the counter or stamp chunk when the chooser points at it
            if (chunk_sel_q == CHUNK_COUNT) begin
               count_en_q <= w_data_q[CHUNK_EN_BIT]; // see R8
            end
            if (chunk_sel_q == CHUNK_STAMP) begin
               stamp_en_q <= w_data_q[CHUNK_EN_BIT]; // see R7
            end
         end
      end
   end

   // Clear configuration; origin resets to off so no clear can occur
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         cnt_inst_q <= CNT_INST_FIRST;
         cnt_evt_q <= CNT_EVT_NONE;
         clr_src_q <= CLR_OFF; // see R15
      end else begin
         if (wr_cnt_sel) begin
            cnt_inst_q <= w_data_q[1:0];
         end
         if (wr_cnt_evt) begin
            cnt_evt_q <= w_data_q[1:0];
         end
         if (wr_clr_src) begin
            clr_src_q <= fta_clear_origin_t'(w_data_q[2:0]);
         end
      end
   end

   // Clear request decode; unused origin codes behave as off
   logic clr_armed;
   logic clr_req;
   assign clr_armed = cnt_inst_q == CNT_INST_SECOND && cnt_evt_q == CNT_EVT_FRAME_BEGIN; // see R16
   assign clr_req = clr_armed && (
      (clr_src_q == CLR_LINE_ONE && line_rise[0]) || // see R14, R18
      (clr_src_q == CLR_LINE_TWO && line_rise[1]) ||
      (clr_src_q == CLR_LINE_THREE && line_rise[2]) ||
      (clr_src_q == CLR_SOFT && wr_clr_cmd)); // see R17

   // A frame begin in the clear cycle still counts, so it reads 1, not 0
   assign frame_cnt_d = (clr_req ? '0 : frame_cnt_q) + CNT_W'(FRAME_BEGIN_EVENT); // see R10, R11

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         frame_cnt_q <= '0; // see R12
      end else begin
         frame_cnt_q <= frame_cnt_d;
      end
   end

   // Stream handshakes: output register reloads when empty or drained
   logic out_load;
   logic in_fire;
   logic trail_fire;
   logic [3:0] idx_next;
   assign out_load = !out_valid_q || TX_READY;
   assign IMG_READY = out_load && state_q == ST_IMAGE;
   assign in_fire = IMG_VALID && IMG_READY;
   assign trail_fire = out_load && state_q == ST_TRAIL;
   assign idx_next = next_word(idx_q, count_on_q, stamp_on_q);

   // Trailer word select
   logic [DATA_W-1:0] trail_word;
   always_comb begin
      trail_word = '0;
      unique case (idx_q)
         W_OFFX: trail_word = DATA_W'(info_snap_q.offset_x); // see R5
         W_WIDTH: trail_word = DATA_W'(info_snap_q.width);
         W_HEIGHT: trail_word = DATA_W'(info_snap_q.height);
         W_PIXFMT: trail_word = info_snap_q.pix_fmt;
         W_DRMIN: trail_word = DATA_W'(info_snap_q.dr_min);
         W_DRMAX: trail_word = DATA_W'(info_snap_q.dr_max);
         W_COUNT: trail_word = DATA_W'(cnt_snap_q); // see R9
         W_STAMP_LO: trail_word = stamp_snap_q[DATA_W-1:0];
         W_STAMP_HI: trail_word = stamp_snap_q[STAMP_W-1:DATA_W];
         default: trail_word = '0;
      endcase
   end

   // Stamp taken when the frame starts, then parked for its trailer
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         stamp_begin_q <= '0;
      end else if (FRAME_BEGIN_EVENT) begin
         stamp_begin_q <= stamp_now; // see R20
      end
   end

   // Snapshots at the last image beat so later writes cannot tear a trailer
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         info_snap_q <= '0;
         cnt_snap_q <= '0;
         stamp_snap_q <= '0;
         count_on_q <= 1'b0;
         stamp_on_q <= 1'b0;
      end else if (in_fire && IMG_BEAT.last) begin
         info_snap_q <= FRAME_INFO;
         cnt_snap_q <= frame_cnt_q; // see R13
         stamp_snap_q <= stamp_begin_q;
         count_on_q <= count_en_q && mode_q;
         stamp_on_q <= stamp_en_q && mode_q;
      end
   end

   // Sequencer: image beats pass, then the trailer words in fixed order
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         state_q <= ST_IMAGE;
         idx_q <= W_OFFX;
      end else begin
         unique case (state_q)
            ST_IMAGE: begin
               if (in_fire && IMG_BEAT.last && mode_q) begin
                  state_q <= ST_TRAIL; // see R6
                  idx_q <= W_OFFX; // see R19
               end
            end
            ST_TRAIL: begin
               if (trail_fire) begin
                  idx_q <= idx_next;
                  if (idx_next == W_DONE) begin
                     state_q <= ST_IMAGE;
                  end
               end
            end
            default: state_q <= ST_IMAGE;
         endcase
      end
   end

   // Output register; frame end marker moves onto the final trailer word
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         out_valid_q <= 1'b0;
         out_q <= '0;
      end else if (in_fire) begin
         out_valid_q <= 1'b1;
         out_q <= '{data: IMG_BEAT.data, last: IMG_BEAT.last && !mode_q};
      end else if (trail_fire) begin
         out_valid_q <= 1'b1;
         out_q <= '{data: trail_word, last: idx_next == W_DONE}; // see R19
      end else if (TX_READY) begin
         out_valid_q <= 1'b0;
      end
   end

   assign TX_VALID = out_valid_q;
   assign TX_BEAT = out_q;
   assign PAYLOAD_KIND = mode_q; // see R4
endmodule

// File: verif/fta_checker.sv
`timescale 1ns/1ps
module fta_checker (
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   input wire logic S_AXI_AWVALID,
   input wire logic S_AXI_AWREADY,
   input wire logic S_AXI_WVALID,
   input wire logic S_AXI_WREADY,
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic S_AXI_RVALID,
   input wire fta_pkg::fta_beat_t IMG_BEAT,
   input wire logic IMG_VALID,
   input wire logic IMG_READY,
   input wire fta_pkg::fta_beat_t TX_BEAT,
   input wire logic TX_VALID,
   input wire logic TX_READY,
   input wire logic PAYLOAD_KIND
);
   import fta_pkg::*;
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RESET_N);
   // Last image beat taken; mode is snapshot here
   wire img_end = IMG_VALID && IMG_READY && IMG_BEAT.last;
   property p_kind_by_write;
      $changed(PAYLOAD_KIND) |-> $rose(S_AXI_BVALID);
   endproperty
   a_kind_by_write: assert property (p_kind_by_write) else $error("payload kind moved without a write");
   property p_write_answer;
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |=> !S_AXI_BVALID ##1 S_AXI_BVALID;
   endproperty
   a_write_answer: assert property (p_write_answer) else $error("write response late or early");
   property p_read_answer;
      S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("read data late");
   property p_read_block;
      S_AXI_RVALID |-> !S_AXI_ARREADY;
   endproperty
   a_read_block: assert property (p_read_block) else $error("read address taken with data pending");
   property p_write_block;
      S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY;
   endproperty
   a_write_block: assert property (p_write_block) else $error("write taken with response pending");
   property p_plain_end;
      img_end && !PAYLOAD_KIND |=> TX_VALID && TX_BEAT.last;
   endproperty
   a_plain_end: assert property (p_plain_end) else $error("plain frame did not end on image beat");
   property p_trail_start;
      img_end && PAYLOAD_KIND |=> TX_VALID && !TX_BEAT.last && !IMG_READY;
   endproperty
   a_trail_start: assert property (p_trail_start) else $error("trailer did not follow image");
   property p_tx_hold;
      TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_BEAT);
   endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("stalled beat changed");
endmodule

bind fta_trailer_top fta_checker fta_checker_i (.SYS_CLK, .RESET_N, .S_AXI_AWVALID, .S_AXI_AWREADY,
   .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID,
   .IMG_BEAT, .IMG_VALID, .IMG_READY, .TX_BEAT, .TX_VALID, .TX_READY, .PAYLOAD_KIND);

// File: verif/fta_host_sink.sv
`timescale 1ns/1ps
module fta_host_sink (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic slow,
   input wire fta_pkg::fta_beat_t beat,
   input wire logic valid,
   output logic ready
);
   import fta_pkg::*;
   fta_beat_t got[$];
   logic [1:0] ph_q;
   // A slow host takes one beat in four, so the sender must hold its beat
   assign ready = !slow || (ph_q == 2'h3);
   // Collect image and trailing words in arrival order
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ph_q <= 2'h0;
      end else begin
         ph_q <= ph_q + 2'h1;
         if (valid && ready) begin
            got.push_back(beat);
         end
      end
   end
endmodule

// File: verif/test_frame_trailer_chunk_appender.sv
`timescale 1ns/1ps
module test_frame_trailer_chunk_appender;
   import fta_pkg::*;
   localparam int CW = 8;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [ADDR_W-1:0] aw = '0;
   logic [ADDR_W-1:0] ar = '0;
   logic [DATA_W-1:0] wd = '0;
   logic awv = 1'b0;
   logic wv = 1'b0;
   logic brdy = 1'b0;
   logic arv = 1'b0;
   logic rrdy = 1'b0;
   logic fbe = 1'b0;
   logic slow = 1'b0;
   logic iv = 1'b0;
   logic [LINE_N-1:0] lines = '0;
   fta_beat_t ib = '0;
   fta_frame_info_t info = '{16'h0010, 16'h0280, 16'h01e0, 32'h0a0b_0001, 16'h0004, 16'h00ff};
   logic awr, wrdy, bv, arr, rv, irdy, tv, trdy, kind;
   logic [1:0] br, rr;
   logic [DATA_W-1:0] rdat;
   logic [31:0] ew [6];
   fta_beat_t tx;
   int failures = 0;
   int compares = 0;
   int cnt = 0;
   int cyc = 0;
   int t0 = 0;
   int k;

   fta_trailer_top #(.CNT_W(CW)) fta_trailer_top_i (.SYS_CLK(clk), .RESET_N(reset_n),
      .S_AXI_AWADDR(aw), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf),
      .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(brdy),
      .S_AXI_ARADDR(ar), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr),
      .S_AXI_RVALID(rv), .S_AXI_RREADY(rrdy), .FRAME_BEGIN_EVENT(fbe), .INPUT_LINES(lines),
      .FRAME_INFO(info), .IMG_BEAT(ib), .IMG_VALID(iv), .IMG_READY(irdy), .TX_BEAT(tx), .TX_VALID(tv),
      .TX_READY(trdy), .PAYLOAD_KIND(kind));
   fta_host_sink fta_host_sink_i (.clk(clk), .reset_n(reset_n), .slow(slow), .beat(tx), .valid(tv),
      .ready(trdy));

   // Clock and a cycle count for the stamp estimate
   always #2.5 clk = ~clk;
   always @(posedge clk) if (reset_n) cyc <= cyc + 1;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge clk);
      aw <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      brdy <= 1'b1;
      do @(posedge clk); while (!(awr && wrdy));
      awv <= 1'b0;
      wv <= 1'b0;
      do @(posedge clk); while (!bv);
      brdy <= 1'b0;
      chk(br, RESP_OKAY);
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
      @(posedge clk);
      ar <= a;
      arv <= 1'b1;
      rrdy <= 1'b1;
      do @(posedge clk); while (!arr);
      arv <= 1'b0;
      do @(posedge clk); while (!rv);
      rrdy <= 1'b0;
      chk(rdat, e);
      chk(rr, er);
   endtask
   // One frame start; the model counter wraps at the instance width
   task automatic pulse();
      @(posedge clk);
      fbe <= 1'b1;
      @(posedge clk);
      t0 = cyc;
      fbe <= 1'b0;
      cnt = (cnt + 1) & ((1 << CW) - 1);
   endtask
   task automatic set_lines(input logic [2:0] v);
      @(posedge clk);
      lines <= v;
      repeat (5) @(posedge clk);
   endtask
   // Sends n image beats, then expects len words ending on one last flag
   task automatic frame(input int n, input int len);
      int i;
      fta_host_sink_i.got.delete();
      pulse();
      for (i = 0; i < n; i++) begin
         ib.data <= 32'hc0de_0000 + i;
         ib.last <= (i == n - 1);
         iv <= 1'b1;
         do @(posedge clk); while (!irdy);
      end
      iv <= 1'b0;
      for (i = 0; i < 300 && fta_host_sink_i.got.size() < len; i++) @(posedge clk);
      repeat (10) @(posedge clk);
      chk(fta_host_sink_i.got.size(), len);
      for (i = 0; i < len; i++) chk(fta_host_sink_i.got[i].last, i == len - 1);
      for (i = 0; i < n; i++) chk(fta_host_sink_i.got[i].data, 32'hc0de_0000 + i);
   endtask
   task automatic end_sim;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (40000) @(posedge clk);
      failures++;
      end_sim();
   end

   initial begin
      ew = '{{16'h0, info.offset_x}, {16'h0, info.width}, {16'h0, info.height}, info.pix_fmt,
         {16'h0, info.dr_min}, {16'h0, info.dr_max}};
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      rd(ADDR_FRAME_CNT, 0);
      rd(ADDR_CLR_SRC, CLR_OFF);
      rd(ADDR_STATUS, 0);
      rd(6'h3c, 0, RESP_SLVERR);
      // Enables are refused while trailer mode is off
      wr(ADDR_CHUNK_SEL, CHUNK_COUNT);
      wr(ADDR_CHUNK_EN, 1);
      rd(ADDR_CHUNK_EN, 0);
      frame(3, 3);
      wr(ADDR_MODE, 1);
      rd(ADDR_STATUS, 1);
      chk(kind, 1);
      wr(ADDR_CHUNK_SEL, CHUNK_INFO);
      rd(ADDR_CHUNK_EN, 1);
      wr(ADDR_CHUNK_SEL, CHUNK_COUNT);
      wr(ADDR_CHUNK_EN, 1);
      slow <= 1'b1;
      frame(2, 9);
      for (k = 0; k < 6; k++) chk(fta_host_sink_i.got[k + 2].data, ew[k]);
      chk(fta_host_sink_i.got[8].data, cnt);
      wr(ADDR_CHUNK_SEL, CHUNK_STAMP);
      wr(ADDR_CHUNK_EN, 1);
      frame(1, 10);
      chk(fta_host_sink_i.got[7].data, cnt);
      k = fta_host_sink_i.got[8].data;
      chk((k >= t0 * 5 / 8 - 3) && (k <= t0 * 5 / 8 + 3), 1);
      chk(fta_host_sink_i.got[9].data, 0);
      slow <= 1'b0;
      // Line clear: the next line over ignored, one clear per rising edge
      wr(ADDR_CNT_SEL, CNT_INST_SECOND);
      wr(ADDR_CNT_EVT, CNT_EVT_FRAME_BEGIN);
      for (k = 0; k < 3; k++) begin
         wr(ADDR_CLR_SRC, k + 1);
         pulse();
         set_lines(3'b001 << ((k + 1) % 3));
         rd(ADDR_FRAME_CNT, cnt);
         set_lines(3'b001 << k);
         cnt = 0;
         pulse();
         rd(ADDR_FRAME_CNT, cnt);
         set_lines(3'b000);
      end
      wr(ADDR_CLR_SRC, CLR_SOFT);
      pulse();
      wr(ADDR_CLR_CMD, 1);
      cnt = 0;
      rd(ADDR_FRAME_CNT, cnt);
      wr(ADDR_CLR_SRC, CLR_OFF);
      pulse();
      set_lines(3'b111);
      rd(ADDR_FRAME_CNT, cnt);
      set_lines(3'b000);
      // Run the counter past its top value
      for (k = 0; k < (1 << CW) - 1; k++) pulse();
      rd(ADDR_FRAME_CNT, 0);
      // Mode off drops every enable
      wr(ADDR_MODE, 0);
      rd(ADDR_STATUS, 0);
      wr(ADDR_MODE, 1);
      rd(ADDR_CHUNK_EN, 0);
      frame(1, 7);
      end_sim();
   end
endmodule
